// [rtl/tcd_command_decoder.sv]
`timescale 1ns/10ps
`include "tcd_defs.svh"
// Behaviour
// R1 - msb set means conversion command byte fields
// R2 - host sends byte after acked write address
// R3 - codes 0000/0001 repeat scan until lift/stop
// R4 - single scans convert X, Y or Z once
// R5 - aux once, or continuously for 1000
// R6 - temperature plain or differential into own register
// R7 - 1001 X test: pin low, result reported
// R8 - 1010 Y test: pin low, result reported
// R9 - 1100 short test: pin low, one if none
// R10 - host sets all range bits before short test
// R11 - host picks range, runs X, Y separately
// R12 - reserved 1011 condition cleared by stop
// R13 - top three codes select driver status settings
// R14 - mode one: stored scan starts on touch
// R15 - mode one: stored scan reused every touch
// R16 - mode zero: host rewrites scan each touch
// R17 - sequential read blocks data register updates
// R18 - resolution bit shared with first config word
// R19 - soft reset restores defaults, self clears
// R20 - stop aborts function, powers down, self clears
// R21 - stop leaves data, status, config untouched; the stop byte still loads resolution_select from its resolution bit
// R22 - stop bit read only through first config word
// R23 - latch code when byte received and acknowledged
module tcd_command_decoder
  import tcd_pkg::*;
#(
  parameter int FN_W = 4
) (
  // system clock and reset
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  // serial-side command strobe, link clock domain
  input  wire logic                 linkClk,
  input  wire logic [7:0]           cmdByte,
  input  wire logic                 cmdAcked,
  input  wire logic                 seqReadActive,
  // configuration
  input  wire logic                 scan_control_mode_bit,
  // converter handshake
  output logic [`TCD_NCH-1:0]       convReq,
  input  wire logic                 convDone,
  input  wire logic                 penDown,
  input  wire logic                 testPass,
  output logic [1:0]                testKind,
  output logic [1:0]                driverSel,
  output logic                      convPowerDown,
  output logic                      dataUpdateBlock,
  // status and pin
  output logic                      pen_irq_data_avail_pin,
  output logic                      testResult,
  output logic [FN_W-1:0]           conv_func_select,
  output logic                      resolution_select,
  output logic                      conv_halt_bit,
  output logic                      regSoftReset,
  output logic                      funcBusy
);

  initial begin
    if (FN_W != 4) $error("function code must be four bits");
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: capture byte, toggle an event flag
  logic [7:0] linkByte_reg;             // held byte, stable across crossing
  logic [7:0] linkByte_next;
  logic       linkTgl_reg;              // event toggle
  logic       linkTgl_next;

  // capture only command bytes with id bit set, see R1 see R23
  always_comb begin
    linkByte_next = linkByte_reg;
    linkTgl_next  = linkTgl_reg;
    if (cmdAcked && cmdByte[`TCD_ID_BIT]) begin  // see R2
      linkByte_next = cmdByte;
      linkTgl_next  = ~linkTgl_reg;
    end
  end

  // link clock may stop between frames and through reset, so these
  // flops clear without it; an unknown toggle would never cross
  always_ff @(posedge linkClk or posedge sys_rst) begin
    if (sys_rst) begin
      linkByte_reg <= 8'h00;
      linkTgl_reg  <= 1'h0;
    end else begin
      linkByte_reg <= linkByte_next;
      linkTgl_reg  <= linkTgl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crossing into mclk: toggle through two flops, byte sampled after
  logic       tglS1_reg, tglS2_reg, tglS3_reg;
  logic       seqS1_reg, seqS2_reg;     // sequential-read level sync
  logic       penS1_reg, penS2_reg;     // pen pin sync
  logic [7:0] cmdHeld_reg;
  logic [7:0] cmdHeld_next;
  logic       cmdEv_reg;                // one-cycle new-command pulse
  logic       cmdEv_next;

  // byte is quiet for many mclk cycles once the toggle lands
  always_comb begin
    cmdEv_next   = tglS2_reg ^ tglS3_reg;
    cmdHeld_next = cmdEv_next ? linkByte_reg : cmdHeld_reg;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      tglS1_reg   <= 1'h0;
      tglS2_reg   <= 1'h0;
      tglS3_reg   <= 1'h0;
      seqS1_reg   <= 1'h0;
      seqS2_reg   <= 1'h0;
      penS1_reg   <= 1'h0;
      penS2_reg   <= 1'h0;
      cmdHeld_reg <= 8'h00;
      cmdEv_reg   <= 1'h0;
    end else begin
      tglS1_reg   <= linkTgl_reg;
      tglS2_reg   <= tglS1_reg;
      tglS3_reg   <= tglS2_reg;
      seqS1_reg   <= seqReadActive;
      seqS2_reg   <= seqS1_reg;
      penS1_reg   <= penDown;
      penS2_reg   <= penS1_reg;
      cmdHeld_reg <= cmdHeld_next;
      cmdEv_reg   <= cmdEv_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command field split
  logic [3:0] newFn;
  logic       newRes, newSrst, newHalt;
  assign newFn   = cmdHeld_reg[`TCD_FN_HI:`TCD_FN_LO];   // see R1
  assign newRes  = cmdHeld_reg[`TCD_RES_BIT];
  assign newSrst = cmdHeld_reg[`TCD_SRST_BIT];
  assign newHalt = cmdHeld_reg[`TCD_HALT_BIT];

  // channel set for a function code
  function automatic logic [`TCD_NCH-1:0] chanOf(input logic [3:0] fn);
    logic [`TCD_NCH-1:0] c;
    c = '0;
    case (fn)
      `TCD_FN_XYZ: begin
        c[`TCD_CH_X] = 1'h1; c[`TCD_CH_Y] = 1'h1;  // see R3
        c[`TCD_CH_Z1] = 1'h1; c[`TCD_CH_Z2] = 1'h1;
      end
      `TCD_FN_XY: begin
        c[`TCD_CH_X] = 1'h1; c[`TCD_CH_Y] = 1'h1;  // see R3
      end
      `TCD_FN_X:     c[`TCD_CH_X] = 1'h1;         // see R4
      `TCD_FN_Y:     c[`TCD_CH_Y] = 1'h1;         // see R4
      `TCD_FN_Z: begin
        c[`TCD_CH_Z1] = 1'h1; c[`TCD_CH_Z2] = 1'h1;  // see R4
      end
      `TCD_FN_AUX, `TCD_FN_AUXC: c[`TCD_CH_AUX] = 1'h1;  // see R5
      `TCD_FN_TEMP1: c[`TCD_CH_T1] = 1'h1;        // see R6
      `TCD_FN_TEMP2: c[`TCD_CH_T2] = 1'h1;        // see R6
      default:       c = '0;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // function sequencer
  tcd_state_t          state_reg, state_next;
  logic [3:0]          fn_reg, fn_next;           // latched code
  logic                res_reg, res_next;         // resolution storage
  logic                halt_reg, halt_next;       // halt pulse
  logic                srst_reg, srst_next;       // soft reset pulse
  logic                pin_reg, pin_next;         // pen/data pin level
  logic                tres_reg, tres_next;       // test result status
  logic [`TCD_NCH-1:0] req_reg, req_next;
  logic [1:0]          tk_reg, tk_next;
  logic [1:0]          drv_reg, drv_next;
  logic                pd_reg, pd_next;           // converter powered down
  logic                blk_reg, blk_next;
  logic                isScan, isRepeat, isTest;

  assign isScan   = (fn_reg == `TCD_FN_XYZ) || (fn_reg == `TCD_FN_XY);
  assign isRepeat = isScan || (fn_reg == `TCD_FN_AUXC);
  assign isTest   = (fn_reg == `TCD_FN_XTST) || (fn_reg == `TCD_FN_YTST)
                    || (fn_reg == `TCD_FN_SHRT);

  // next-state: decode, start, repeat, test report, stop
  always_comb begin
    state_next = state_reg;
    fn_next    = fn_reg;
    res_next   = res_reg;
    halt_next  = 1'h0;                            // self clearing, see R20
    srst_next  = 1'h0;                            // self clearing, see R19
    pin_next   = pin_reg;
    tres_next  = tres_reg;
    req_next   = '0;
    tk_next    = tk_reg;
    drv_next   = drv_reg;
    pd_next    = pd_reg;
    blk_next   = seqS2_reg;                       // see R17
    case (state_reg)
      TCD_IDLE: begin
        pd_next = 1'h1;
      end
      TCD_ISSUE: begin
        pd_next = 1'h0;
        if (isTest) begin
          pin_next = 1'h0;                        // see R7 see R8 see R9
        end
        req_next   = chanOf(fn_reg);
        state_next = TCD_WAIT;
      end
      TCD_WAIT: begin
        if (isScan && !penS2_reg) begin
          // pen lifted: stop scanning, keep the code, and rearm it only in mode one
          state_next = scan_control_mode_bit ? TCD_ARMED : TCD_IDLE;  // see R15
        end else if (convDone) begin
          if (isTest) begin
            tres_next  = testPass;                // see R7 see R8 see R9
            pin_next   = testPass;
            state_next = testPass ? TCD_DONE : TCD_HOLD;
          end else if (isRepeat) begin
            state_next = TCD_ISSUE;               // see R3 see R5
          end else begin
            state_next = TCD_DONE;                // see R4 see R6 see R13
          end
        end
      end
      TCD_HOLD: begin
        pin_next = 1'h0;                          // low until stop, see R12
      end
      TCD_ARMED: begin
        pd_next = 1'h1;
        if (!scan_control_mode_bit) begin
          state_next = TCD_IDLE;                  // see R16
        end else if (penS2_reg) begin
          state_next = TCD_ISSUE;                 // see R14
        end
      end
      TCD_DONE: begin
        state_next = TCD_IDLE;
      end
      default: state_next = TCD_IDLE;
    endcase
    // a newly arrived command byte overrides the sequence
    if (cmdEv_reg) begin
      res_next = newRes;                          // see R18
      if (newSrst) begin
        srst_next  = 1'h1;                        // see R19
        res_next   = `TCD_RES_RST;
        fn_next    = `TCD_FN_XYZ;
        tres_next  = 1'h0;
        pin_next   = 1'h1;
        drv_next   = 2'h0;
        tk_next    = 2'h0;                        // see R19
        req_next   = '0;
        state_next = TCD_IDLE;
      end else if (newHalt) begin
        halt_next  = 1'h1;                        // see R20 see R21 see R22
        pin_next   = 1'h1;                        // see R12
        req_next   = '0;
        state_next = TCD_IDLE;
      end else begin
        fn_next  = newFn;                         // see R23
        tk_next  = (newFn == `TCD_FN_XTST) ? `TCD_TST_X :
                   (newFn == `TCD_FN_YTST) ? `TCD_TST_Y :
                   (newFn == `TCD_FN_SHRT) ? `TCD_TST_S : 2'h0;
        drv_next = (newFn == `TCD_FN_DRVX)  ? 2'h1 :   // see R13
                   (newFn == `TCD_FN_DRVY)  ? 2'h2 :
                   (newFn == `TCD_FN_DRVYX) ? 2'h3 : 2'h0;
        if (newFn == `TCD_FN_RSVD) begin
          state_next = TCD_HOLD;                  // see R12
        end else if (((newFn == `TCD_FN_XYZ) || (newFn == `TCD_FN_XY))
                     && !penS2_reg) begin
          state_next = scan_control_mode_bit ? TCD_ARMED : TCD_IDLE;  // see R14
        end else begin
          state_next = TCD_ISSUE;
        end
      end
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= TCD_IDLE;
      fn_reg    <= `TCD_FN_XYZ;
      res_reg   <= `TCD_RES_RST;
      halt_reg  <= 1'h0;
      srst_reg  <= 1'h0;
      pin_reg   <= 1'h1;
      tres_reg  <= 1'h0;
      req_reg   <= '0;
      tk_reg    <= 2'h0;
      drv_reg   <= 2'h0;
      pd_reg    <= 1'h1;
      blk_reg   <= 1'h0;
    end else begin
      state_reg <= state_next;
      fn_reg    <= fn_next;
      res_reg   <= res_next;
      halt_reg  <= halt_next;
      srst_reg  <= srst_next;
      pin_reg   <= pin_next;
      tres_reg  <= tres_next;
      req_reg   <= req_next;
      tk_reg    <= tk_next;
      drv_reg   <= drv_next;
      pd_reg    <= pd_next;
      blk_reg   <= blk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from flops
  assign convReq                = req_reg;
  assign testKind               = tk_reg;
  assign driverSel              = drv_reg;
  assign convPowerDown          = pd_reg;
  assign dataUpdateBlock        = blk_reg;
  assign pen_irq_data_avail_pin = pin_reg;
  assign testResult             = tres_reg;
  assign conv_func_select       = fn_reg;
  assign resolution_select      = res_reg;
  assign conv_halt_bit          = halt_reg;
  assign regSoftReset           = srst_reg;
  // busy is registered from the next-state decode
  logic busy_reg;
  always_ff @(posedge mclk) begin
    if (sys_rst) busy_reg <= 1'h0;
    else         busy_reg <= (state_next == TCD_ISSUE) || (state_next == TCD_WAIT);
  end
  assign funcBusy = busy_reg;

endmodule

// [rtl/tcd_defs.svh]
`ifndef TCD_DEFS_SVH
`define TCD_DEFS_SVH
// control byte layout
`define TCD_ID_BIT      7
`define TCD_FN_HI       6
`define TCD_FN_LO       3
`define TCD_RES_BIT     2
`define TCD_SRST_BIT    1
`define TCD_HALT_BIT    0
// function codes
`define TCD_FN_XYZ      4'h0
`define TCD_FN_XY       4'h1
`define TCD_FN_X        4'h2
`define TCD_FN_Y        4'h3
`define TCD_FN_Z        4'h4
`define TCD_FN_AUX      4'h5
`define TCD_FN_TEMP1    4'h6
`define TCD_FN_TEMP2    4'h7
`define TCD_FN_AUXC     4'h8
`define TCD_FN_XTST     4'h9
`define TCD_FN_YTST     4'ha
`define TCD_FN_RSVD     4'hb
`define TCD_FN_SHRT     4'hc
`define TCD_FN_DRVX     4'hd
`define TCD_FN_DRVY     4'he
`define TCD_FN_DRVYX    4'hf
// channel one-hot positions in the conversion request
`define TCD_CH_X        0
`define TCD_CH_Y        1
`define TCD_CH_Z1       2
`define TCD_CH_Z2       3
`define TCD_CH_AUX      4
`define TCD_CH_T1       5
`define TCD_CH_T2       6
`define TCD_NCH         7
// test kinds
`define TCD_TST_X       2'h1
`define TCD_TST_Y       2'h2
`define TCD_TST_S       2'h3
// reset values
`define TCD_RES_RST     1'h1
`endif

// [rtl/tcd_pkg.sv]
package tcd_pkg;
  // decoder sequencing states, gray along idle-issue-wait-done
  typedef enum logic [2:0] {
    TCD_IDLE  = 3'h0,
    TCD_ISSUE = 3'h1,
    TCD_WAIT  = 3'h3,
    TCD_DONE  = 3'h2,
    TCD_HOLD  = 3'h6,
    TCD_ARMED = 3'h7
  } tcd_state_t;
endpackage

// [test/tcd_command_decoder_properties.sv]
`timescale 1ns/10ps
`include "tcd_defs.svh"
module tcd_checker
  import tcd_pkg::*;
#(
  parameter int FN_W = 4
) (
  // clock and reset
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  // watched ports
  input wire logic                 seqReadActive,
  input wire logic [`TCD_NCH-1:0]  convReq,
  input wire logic                 convDone,
  input wire logic                 testPass,
  input wire logic [1:0]           testKind,
  input wire logic                 convPowerDown,
  input wire logic                 dataUpdateBlock,
  input wire logic                 pen_irq_data_avail_pin,
  input wire logic [FN_W-1:0]      conv_func_select,
  input wire logic                 resolution_select,
  input wire logic                 conv_halt_bit,
  input wire logic                 regSoftReset,
  input wire logic                 funcBusy
);
  // one domain, so clocking and reset are stated once
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////
  chk_req_pulse: assert property (|convReq |=> convReq == '0)
    else $error("conversion request longer than one cycle");
  chk_halt_pulse: assert property (conv_halt_bit |=> !conv_halt_bit)
    else $error("stop pulse did not clear itself");
  chk_srst_pulse: assert property (regSoftReset |=> !regSoftReset)
    else $error("soft reset pulse did not clear itself");
  chk_srst_dflt: assert property (regSoftReset |-> ##[0:1]
    (conv_func_select == '0 && resolution_select)) else $error("soft reset left state");
  chk_halt_pin: assert property (conv_halt_bit |-> ##[0:1] pen_irq_data_avail_pin)
    else $error("pin not released by stop");
  chk_busy_power: assert property (funcBusy && $past(funcBusy) |-> !convPowerDown)
    else $error("powered down while busy");
  chk_block_delay: assert property ($rose(seqReadActive) |-> ##[2:4] dataUpdateBlock)
    else $error("data update block late");
  chk_test_low: assert property (funcBusy && $past(funcBusy) && testKind != 2'h0
    |-> !pen_irq_data_avail_pin) else $error("pin high during panel test");
  chk_pass_pin: assert property (convDone && funcBusy && testKind != 2'h0 && testPass
    |-> ##[1:2] pen_irq_data_avail_pin) else $error("passing test not shown on pin");
endmodule
bind tcd_command_decoder tcd_checker #(.FN_W(FN_W)) tcd_checker_i (.mclk, .sys_rst,
  .seqReadActive, .convReq, .convDone, .testPass, .testKind, .convPowerDown,
  .dataUpdateBlock, .pen_irq_data_avail_pin, .conv_func_select, .resolution_select,
  .conv_halt_bit, .regSoftReset, .funcBusy);

// [test/tcd_host_model.sv]
`timescale 1ns/10ps
module tcd_host_model (
  // link side towards the decoder
  output logic       linkClk,
  output logic [7:0] cmdByte,
  output logic       cmdAcked
);
  // link clock stands still between frames
  initial begin
    linkClk = 1'b0;
    cmdByte = 8'h00;
    cmdAcked = 1'b0;
  end
  // one acked byte per frame, a single link edge carries it
  task automatic send(input logic [7:0] b);
    cmdByte = b;
    cmdAcked = 1'b1;
    #23 linkClk = 1'b1;
    #40 linkClk = 1'b0;
    cmdAcked = 1'b0;
    // released byte shows garbage, not the last value
    cmdByte = ~b;
  endtask
endmodule

// [test/tcd_command_decoder_tb.sv]
`timescale 1ns/10ps
`include "tcd_defs.svh"
module tcd_command_decoder_tb
  import tcd_pkg::*;
;
  // stimulus and observed ports
  logic mclk = 0, sys_rst, seqReadActive, scan_control_mode_bit;
  logic convDone, penDown, testPass;
  logic linkClk, cmdAcked, convPowerDown, dataUpdateBlock, pen_irq_data_avail_pin;
  logic testResult, resolution_select, conv_halt_bit, regSoftReset, funcBusy;
  logic [7:0] cmdByte;
  logic [6:0] convReq;
  logic [1:0] testKind, driverSel;
  logic [3:0] conv_func_select;
  int failCount = 0, comparisons = 0;
  // expected request per scan code, and test codes
  logic [6:0] msk[9] = '{7'h0f, 7'h03, 7'h01, 7'h02, 7'h0c, 7'h10, 7'h20, 7'h40, 7'h10};
  logic [3:0] tcode[3] = '{4'h9, 4'ha, 4'hc};
  always #4 mclk = ~mclk;
  tcd_host_model tcd_host_model_i (.linkClk(linkClk), .cmdByte(cmdByte), .cmdAcked(cmdAcked));
  tcd_command_decoder tcd_command_decoder_i (.mclk, .sys_rst, .linkClk, .cmdByte, .cmdAcked,
    .seqReadActive, .scan_control_mode_bit, .convReq, .convDone, .penDown, .testPass,
    .testKind, .driverSel, .convPowerDown, .dataUpdateBlock, .pen_irq_data_avail_pin,
    .testResult, .conv_func_select, .resolution_select, .conv_halt_bit, .regSoftReset,
    .funcBusy);
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic logic [7:0] cb(input logic [3:0] c, input logic r);
    return {1'b1, c, r, 2'b00};
  endfunction
  // bounded wait for the one-cycle request pulse, zero if none
  task automatic expReq(input logic [6:0] m);
    int n;
    n = 0;
    while (convReq === 7'h00 && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("convReq", convReq, m);
    cyc(1);
  endtask
  task automatic done(input logic p);
    testPass = p;
    convDone = 1'b1;
    cyc(1);
    convDone = 1'b0;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // watchdog, over ten times the expected run of about a thousand cycles
  initial begin
    #100000;
    failCount++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    seqReadActive = 1'b0;
    scan_control_mode_bit = 1'b0;
    convDone = 1'b0;
    penDown = 1'b1;
    testPass = 1'b0;
    cyc(6);
    sys_rst = 1'b0;
    chk("pin", pen_irq_data_avail_pin, 1);
    chk("res", resolution_select, 1);
    chk("pd", convPowerDown, 1);
    // every scan, aux and temperature code
    for (int i = 0; i < 9; i++) begin
      tcd_host_model_i.send(cb(i[3:0], 1'b1));
      expReq(msk[i]);
      chk("func", conv_func_select, i);
      done(1'b1);
      expReq((i < 2 || i == 8) ? msk[i] : 7'h00);
      tcd_host_model_i.send(8'h81);
      cyc(8);
      chk("busy", funcBusy, 0);
    end
    $display("scan codes done");
    // panel tests, passing and failing
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 2; p++) begin
        tcd_host_model_i.send(cb(tcode[k], 1'b1));
        cyc(8);
        chk("kind", testKind, k + 1);
        chk("pinBusy", pen_irq_data_avail_pin, 0);
        done(p[0]);
        cyc(3);
        chk("pinEnd", pen_irq_data_avail_pin, p);
        tcd_host_model_i.send(8'h81);
        cyc(8);
        chk("pinStop", pen_irq_data_avail_pin, 1);
        chk("status", testResult, p);
      end
    end
    $display("panel tests done");
    for (int d = 0; d < 3; d++) begin
      tcd_host_model_i.send(cb(4'hd + d[3:0], 1'b1));
      cyc(8);
      chk("drv", driverSel, d + 1);
    end
    tcd_host_model_i.send(cb(4'hb, 1'b1));
    cyc(8);
    chk("rsvdPin", pen_irq_data_avail_pin, 0);
    tcd_host_model_i.send(8'h81);
    cyc(8);
    chk("rsvdStop", pen_irq_data_avail_pin, 1);
    $display("driver and reserved done");
    // resolution, soft reset, ignored byte
    tcd_host_model_i.send(cb(4'h2, 1'b0));
    expReq(7'h01);
    chk("res10", resolution_select, 0);
    done(1'b1);
    cyc(3);
    tcd_host_model_i.send(8'h82);
    cyc(8);
    chk("srstRes", resolution_select, 1);
    chk("srstFn", conv_func_select, 0);
    tcd_host_model_i.send(8'h48);
    cyc(8);
    chk("ignored", conv_func_select, 0);
    $display("reset tests done");
    // device-started scans in mode one
    scan_control_mode_bit = 1'b1;
    penDown = 1'b0;
    cyc(4);
    tcd_host_model_i.send(cb(4'h0, 1'b1));
    expReq(7'h00);
    penDown = 1'b1;
    expReq(7'h0f);
    done(1'b1);
    expReq(7'h0f);
    penDown = 1'b0;
    cyc(10);
    penDown = 1'b1;
    expReq(7'h0f);
    tcd_host_model_i.send(8'h81);
    cyc(8);
    seqReadActive = 1'b1;
    cyc(6);
    chk("block", dataUpdateBlock, 1);
    seqReadActive = 1'b0;
    cyc(6);
    chk("unblock", dataUpdateBlock, 0);
    $display("mode and read tests done");
    results();
  end
endmodule
